// ### ufd_pkg.sv
/*
  Package for the FIFO and DMA-request control of one UART channel.
  Holds register offsets, field positions, reset values, FIFO sizing,
  trigger levels and the carrier type for a received character.
  Assumes one 250 MHz clock domain.
*/
package ufd_pkg;

  // Register offsets on the 3-bit register port
  localparam logic [2:0] UFD_ADDR_HOLD  = 3'h0;  // Read: receive holding, write: transmit
  localparam logic [2:0] UFD_ADDR_IEN   = 3'h1;  // Interrupt enable
  localparam logic [2:0] UFD_ADDR_FCTL  = 3'h2;  // FIFO control, write only
  localparam logic [2:0] UFD_ADDR_LSTAT = 3'h5;  // Line status, read only

  // FIFO control field positions
  localparam int UFD_FC_EN     = 0;
  localparam int UFD_FC_RXCLR  = 1;
  localparam int UFD_FC_TXCLR  = 2;
  localparam int UFD_FC_DMA    = 3;
  localparam int UFD_FC_TXTRG  = 4;
  localparam int UFD_FC_RXTRG  = 6;

  // Line status field positions
  localparam int UFD_LS_DR     = 0;
  localparam int UFD_LS_OVR    = 1;
  localparam int UFD_LS_PAR    = 2;
  localparam int UFD_LS_FRM    = 3;
  localparam int UFD_LS_BRK    = 4;
  localparam int UFD_LS_THE    = 5;
  localparam int UFD_LS_TEMT   = 6;
  localparam int UFD_LS_FERR   = 7;

  // Reset values
  localparam logic [7:0] UFD_FCTL_RST = 8'h00;
  localparam logic [3:0] UFD_IEN_RST  = 4'h0;

  // FIFO sizing
  localparam int         UFD_DEPTH  = 32;
  localparam int         UFD_AW     = 5;
  localparam logic [5:0] UFD_FULL   = 6'h20;
  localparam logic [5:0] UFD_ONE    = 6'h01;

  // Receive trigger levels, codes 0..3
  localparam logic [5:0] UFD_RXT0 = 6'h08;
  localparam logic [5:0] UFD_RXT1 = 6'h10;
  localparam logic [5:0] UFD_RXT2 = 6'h18;
  localparam logic [5:0] UFD_RXT3 = 6'h1C;

  // Transmit trigger levels, codes 0..3
  localparam logic [5:0] UFD_TXT0 = 6'h10;
  localparam logic [5:0] UFD_TXT1 = 6'h08;
  localparam logic [5:0] UFD_TXT2 = 6'h18;
  localparam logic [5:0] UFD_TXT3 = 6'h1E;

  // Received character with its error marks
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } ufd_rxchar_t;

endpackage

// ### ufd_ctrl.sv
/*
  FIFO control, line status and DMA request pins for one UART channel.
  Holds the 32-entry transmit and receive FIFOs, the FIFO control and
  interrupt enable registers, and drives the active-low request pins.
  Assumes the serial shifters run on sys_clk and hand characters over
  with one-cycle strobes; no synchronisers are needed on those inputs.
*/
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps

module ufd_ctrl
  import ufd_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Receive shifter side
  input  wire ufd_rxchar_t rx_char,
  input  wire logic        rx_push,
  input  wire logic        rx_timeout,
  // Transmit shifter side
  output logic      [7:0]  tx_data,
  output logic             tx_avail,
  input  wire logic        tx_take,
  input  wire logic        tx_shift_busy,
  // Interrupt and DMA request pins
  output logic             irq,
  output logic             transmit_request_pin_n,
  output logic             receive_request_pin_n
);

  // Control registers
  logic [7:0]        fctl_q;
  logic [3:0]        ien_q;

  // Receive FIFO storage and pointers
  ufd_rxchar_t       rx_mem [UFD_DEPTH];
  logic [UFD_AW-1:0] rx_wp_q;
  logic [UFD_AW-1:0] rx_rp_q;
  logic [5:0]        rx_cnt_q;
  logic [5:0]        rx_errs_q;
  logic              rx_ovr_q;

  // Transmit FIFO storage and pointers
  logic [7:0]        tx_mem [UFD_DEPTH];
  logic [UFD_AW-1:0] tx_wp_q;
  logic [UFD_AW-1:0] tx_rp_q;
  logic [5:0]        tx_cnt_q;

  // Request pin state
  logic              txreq_n_q;
  logic              rxreq_n_q;

  // Decoded controls
  logic              fifo_en;
  logic              dma_one;
  logic [5:0]        rx_trig;
  logic [5:0]        tx_trig;
  logic [5:0]        cap;
  logic              wr_fctl;
  logic              rx_clr;
  logic              tx_clr;
  logic              rx_full;
  logic              tx_full;
  logic              rx_do_push;
  logic              rx_do_pop;
  logic              tx_do_push;
  logic              tx_do_pop;
  ufd_rxchar_t       rx_head;
  logic              head_err;
  logic              in_err;
  logic [7:0]        lstat;
  logic              rx_int;
  logic              tx_int;
  logic              ls_int;

  assign fifo_en = fctl_q[UFD_FC_EN];
  assign dma_one = fctl_q[UFD_FC_DMA];
  assign wr_fctl = reg_wr && (reg_addr == UFD_ADDR_FCTL);

  // Capacity: one holding register when FIFOs are off
  assign cap = fifo_en ? UFD_FULL : UFD_ONE;

  // Clears act as one-cycle pulses, so the bits never stay set
  assign tx_clr = wr_fctl && (reg_wdata[UFD_FC_TXCLR]
                  || (reg_wdata[UFD_FC_EN] != fifo_en));
  assign rx_clr = wr_fctl && (reg_wdata[UFD_FC_RXCLR]
                  || (reg_wdata[UFD_FC_EN] != fifo_en));

  // Receive trigger decode.
  // The level is compared against the fill count, so a trigger of
  // 28 leaves four free entries before an overrun can happen.
  // Software that reprograms the field while data is held sees the
  // new level take effect on the very next cycle.
  always_comb begin
    case (fctl_q[UFD_FC_RXTRG +: 2])
      2'h0:    rx_trig = UFD_RXT0;
      2'h1:    rx_trig = UFD_RXT1;
      2'h2:    rx_trig = UFD_RXT2;
      default: rx_trig = UFD_RXT3;
    endcase
  end

  // Transmit trigger decode; code zero is the default level of sixteen
  always_comb begin
    case (fctl_q[UFD_FC_TXTRG +: 2])
      2'h0:    tx_trig = UFD_TXT0;
      2'h1:    tx_trig = UFD_TXT1;
      2'h2:    tx_trig = UFD_TXT2;
      default: tx_trig = UFD_TXT3;
    endcase
  end

  // FIFO control register; clear bits are not stored
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fctl_q <= UFD_FCTL_RST;
    end else if (wr_fctl) begin
      fctl_q <= {reg_wdata[7:3], 2'h0, reg_wdata[UFD_FC_EN]};
    end
  end

  // Interrupt enable register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ien_q <= UFD_IEN_RST;
    end else if (reg_wr && (reg_addr == UFD_ADDR_IEN)) begin
      ien_q <= reg_wdata[3:0];
    end
  end

  // Receive handshakes; loading goes on past the trigger until full
  assign rx_full    = (rx_cnt_q >= cap);
  assign rx_do_push = rx_push && !rx_full;
  assign rx_do_pop  = reg_rd && (reg_addr == UFD_ADDR_HOLD) && (rx_cnt_q != 6'h00);
  assign rx_head    = rx_mem[rx_rp_q];
  assign head_err   = rx_head.brk | rx_head.frm | rx_head.par;
  assign in_err     = rx_char.brk | rx_char.frm | rx_char.par;

  // Receive storage.
  // The array is not reset: only the pointers and the count decide
  // what is valid, which keeps the storage free of a reset fan-out.
  // A stale head after a clear is therefore harmless, since the
  // status bits that use it are gated by a non-zero count.
  always_ff @(posedge sys_clk) begin
    if (rx_do_push) begin
      rx_mem[rx_wp_q] <= rx_char;
    end
  end

  // Receive pointers and fill count
  always_ff @(posedge sys_clk) begin
    if (!rst_n || rx_clr) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= 6'h00;
    end else begin
      if (rx_do_push) begin
        rx_wp_q <= rx_wp_q + 1'b1;
      end
      if (rx_do_pop) begin
        rx_rp_q <= rx_rp_q + 1'b1;
      end
      if (rx_do_push && !rx_do_pop) begin
        rx_cnt_q <= rx_cnt_q + 6'h01;
      end else if (rx_do_pop && !rx_do_push) begin
        rx_cnt_q <= rx_cnt_q - 6'h01;
      end
    end
  end

  // Count of errored characters held, for the summary status bit
  always_ff @(posedge sys_clk) begin
    if (!rst_n || rx_clr) begin
      rx_errs_q <= 6'h00;
    end else begin
      case ({rx_do_push && in_err, rx_do_pop && head_err})
        2'b10:   rx_errs_q <= rx_errs_q + 6'h01;
        2'b01:   rx_errs_q <= rx_errs_q - 6'h01;
        default: rx_errs_q <= rx_errs_q;
      endcase
    end
  end

  // Overrun is sticky until status is read; a new overrun beats the clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_ovr_q <= 1'b0;
    end else if (rx_push && rx_full) begin
      rx_ovr_q <= 1'b1;
    end else if (reg_rd && (reg_addr == UFD_ADDR_LSTAT)) begin
      rx_ovr_q <= 1'b0;
    end
  end

  // Transmit handshakes; writes to a full FIFO are dropped
  assign tx_full    = (tx_cnt_q >= cap);
  assign tx_do_push = reg_wr && (reg_addr == UFD_ADDR_HOLD) && !tx_full;
  assign tx_do_pop  = tx_take && (tx_cnt_q != 6'h00);
  assign tx_avail   = (tx_cnt_q != 6'h00);
  assign tx_data    = tx_mem[tx_rp_q];

  // Transmit storage.
  // Like the receive side, the array carries no reset; the shifter
  // only looks at tx_data while tx_avail is high.
  // A clear leaves a character already taken by the shifter alone.
  always_ff @(posedge sys_clk) begin
    if (tx_do_push) begin
      tx_mem[tx_wp_q] <= reg_wdata;
    end
  end

  // Transmit pointers and fill count; the shifter is left alone
  always_ff @(posedge sys_clk) begin
    if (!rst_n || tx_clr) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      tx_cnt_q <= 6'h00;
    end else begin
      if (tx_do_push) begin
        tx_wp_q <= tx_wp_q + 1'b1;
      end
      if (tx_do_pop) begin
        tx_rp_q <= tx_rp_q + 1'b1;
      end
      if (tx_do_push && !tx_do_pop) begin
        tx_cnt_q <= tx_cnt_q + 6'h01;
      end else if (tx_do_pop && !tx_do_push) begin
        tx_cnt_q <= tx_cnt_q - 6'h01;
      end
    end
  end

  // Line status word, errors taken from the character at the head
  always_comb begin
    lstat                = 8'h00;
    lstat[UFD_LS_DR]     = (rx_cnt_q != 6'h00);
    lstat[UFD_LS_OVR]    = rx_ovr_q;
    lstat[UFD_LS_PAR]    = tx_avail_dummy(rx_cnt_q) & rx_head.par;
    lstat[UFD_LS_FRM]    = tx_avail_dummy(rx_cnt_q) & rx_head.frm;
    lstat[UFD_LS_BRK]    = tx_avail_dummy(rx_cnt_q) & rx_head.brk;
    lstat[UFD_LS_THE]    = (tx_cnt_q == 6'h00);
    lstat[UFD_LS_TEMT]   = (tx_cnt_q == 6'h00) && !tx_shift_busy;
    lstat[UFD_LS_FERR]   = (rx_errs_q != 6'h00);
  end

  // Head marks only mean something while a character is held
  function automatic logic tx_avail_dummy(input logic [5:0] cnt);
    return (cnt != 6'h00);
  endfunction

  // Read data register, valid the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == UFD_ADDR_HOLD) begin
        reg_rdata <= rx_head.data;
      end else if (reg_addr == UFD_ADDR_IEN) begin
        reg_rdata <= {4'h0, ien_q};
      end else if (reg_addr == UFD_ADDR_LSTAT) begin
        reg_rdata <= lstat;
      end else begin
        reg_rdata <= 8'h00;                                 // Unmapped and write-only
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Transmit request pin: level in mode zero, hysteresis in mode one.
  // The pin is registered, so it lags the fill count by one cycle;
  // an external controller must allow for that one-cycle slack.
  // In mode one the pin holds between the trigger and full, which
  // lets a block transfer run without chattering on every character.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txreq_n_q <= 1'b0;
    end else if (!fifo_en || !dma_one) begin
      txreq_n_q <= (tx_cnt_q != 6'h00);
    end else if (tx_cnt_q >= UFD_FULL) begin
      txreq_n_q <= 1'b1;
    end else if (tx_cnt_q <= tx_trig) begin
      txreq_n_q <= 1'b0;
    end
  end

  // Receive request pin: held low in mode one until the FIFO drains.
  // A time-out only asserts the pin while data is held, since the
  // empty test is checked first and wins over the time-out.
  // Like the transmit pin it lags the fill count by one cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxreq_n_q <= 1'b1;
    end else if (!fifo_en || !dma_one) begin
      rxreq_n_q <= (rx_cnt_q == 6'h00);
    end else if (rx_cnt_q == 6'h00) begin
      rxreq_n_q <= 1'b1;
    end else if ((rx_cnt_q >= rx_trig) || rx_timeout) begin
      rxreq_n_q <= 1'b0;
    end
  end

  assign transmit_request_pin_n = txreq_n_q;
  assign receive_request_pin_n  = rxreq_n_q;

  // Interrupt sources; receive and transmit levels follow the fill, no sticky state.
  // Enable bit three has no source in this block and is only stored.
  // The line-status source follows the overrun and head error bits.
  assign rx_int = fifo_en ? ((rx_cnt_q >= rx_trig) || (rx_timeout && rx_cnt_q != 6'h00))
                          : (rx_cnt_q != 6'h00);
  assign tx_int = fifo_en ? (tx_cnt_q < tx_trig)
                          : (tx_cnt_q == 6'h00);
  assign ls_int = |lstat[UFD_LS_BRK:UFD_LS_OVR];

  // All enables clear gives polled mode with the line quiet
  assign irq = (ien_q[0] && rx_int) || (ien_q[1] && tx_int)
               || (ien_q[2] && ls_int);

endmodule

// ### ufd_ctrl_checker.sv
/*
  Port checker for ufd_ctrl, bound to every instance.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ufd_ctrl_checker
  import ufd_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Shifter sides
  input wire logic       rx_push,
  input wire logic [7:0] tx_data,
  input wire logic       tx_avail,
  // Pins
  input wire logic       irq,
  input wire logic       transmit_request_pin_n,
  input wire logic       receive_request_pin_n
);
  logic [7:0] fc_q;
  logic [3:0] ien_q;
  logic       m0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Shadow of the control registers, since FIFO control cannot be read back
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fc_q  <= 8'h00;
      ien_q <= 4'h0;
    end else if (reg_wr && reg_addr == UFD_ADDR_FCTL) begin
      fc_q <= reg_wdata;
    end else if (reg_wr && reg_addr == UFD_ADDR_IEN) begin
      ien_q <= reg_wdata[3:0];
    end
  end
  // Single-character signalling: mode zero or FIFOs off
  assign m0 = !fc_q[UFD_FC_DMA] || !fc_q[UFD_FC_EN];

  irq_quiet_a: assert property (ien_q == 4'h0 |-> !irq)
    else $error("interrupt raised with all enables clear");
  rx_req_low_a: assert property (m0 && rx_push && !reg_wr && !reg_rd |=> ##1 !receive_request_pin_n)
    else $error("receive request not low after a push");
  tx_req_empty_a: assert property (m0 && !tx_avail |=> !transmit_request_pin_n)
    else $error("transmit request not low while empty");
  tx_req_rise_a: assert property (m0 && reg_wr && reg_addr == UFD_ADDR_HOLD && !tx_avail
                                  |=> ##1 transmit_request_pin_n)
    else $error("transmit request not high after first write");
  tx_load_a: assert property (reg_wr && reg_addr == UFD_ADDR_HOLD && !tx_avail
                              |=> tx_avail && tx_data == $past(reg_wdata))
    else $error("written character not at transmit head");
  tx_clear_a: assert property (reg_wr && reg_addr == UFD_ADDR_FCTL && reg_wdata[UFD_FC_TXCLR]
                               |=> !tx_avail)
    else $error("transmit FIFO not emptied by clear");
  rx_clear_a: assert property (reg_wr && reg_addr == UFD_ADDR_FCTL && reg_wdata[UFD_FC_RXCLR]
                               && !rx_push |=> ##1 receive_request_pin_n)
    else $error("receive request low after receive clear");
  fctl_wo_a: assert property (reg_rd && reg_addr == UFD_ADDR_FCTL |=> reg_rdata == 8'h00)
    else $error("FIFO control read back nonzero");
endmodule

bind ufd_ctrl ufd_ctrl_checker ufd_ctrl_checker_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_push(rx_push),
  .tx_data(tx_data), .tx_avail(tx_avail), .irq(irq),
  .transmit_request_pin_n(transmit_request_pin_n),
  .receive_request_pin_n(receive_request_pin_n)
);

// ### ufd_tx_model.sv
/*
  Transmit shifter stand-in for the ufd_ctrl bench.
  Assumes sys_clk; takes one character when go is high, then is busy nine cycles.
*/
`timescale 1ns/1ps
module ufd_tx_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Bench control
  input  wire logic go,
  // Shifter side of the block
  input  wire logic tx_avail,
  output logic      tx_take,
  output logic      tx_shift_busy
);
  logic [3:0] cnt_q;

  // Busy while a character is on the line
  assign tx_shift_busy = (cnt_q != 4'h0);

  // Slow on purpose, so the bench can count takes one by one
  always_ff @(posedge sys_clk) begin
    tx_take <= 1'b0;
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (go && tx_avail && !tx_take) begin
      tx_take <= 1'b1;
      cnt_q   <= 4'h9;
    end
  end
endmodule

// ### tb_ufd_ctrl.sv
/*
  Self-checking bench for ufd_ctrl.
  Assumes ufd_tx_model as transmit shifter; the bench acts as receive shifter.
*/
`timescale 1ns/1ps
module tb_ufd_ctrl;
  import ufd_pkg::*;
  logic        sys_clk = 1'b0, rst_n = 1'b0, go = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, rx_push = 1'b0, rx_timeout = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, tx_data;
  ufd_rxchar_t rx_char = 11'h000;
  logic        tx_avail, tx_take, tx_shift_busy, irq, tx_pin_n, rx_pin_n;
  logic [5:0]  rxl [4] = '{UFD_RXT0, UFD_RXT1, UFD_RXT2, UFD_RXT3};
  logic [5:0]  txl [4] = '{UFD_TXT0, UFD_TXT1, UFD_TXT2, UFD_TXT3};
  int          fails = 0, checked = 0, n;

  ufd_ctrl ufd_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_char(rx_char), .rx_push(rx_push), .rx_timeout(rx_timeout), .tx_data(tx_data),
    .tx_avail(tx_avail), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy), .irq(irq),
    .transmit_request_pin_n(tx_pin_n), .receive_request_pin_n(rx_pin_n));
  ufd_tx_model ufd_tx_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .go(go),
    .tx_avail(tx_avail), .tx_take(tx_take), .tx_shift_busy(tx_shift_busy));

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  task automatic finish_test();
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A wait that ran out ends the run at once
  task automatic wait_ok(input logic ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t: wait ran out", $time);
      finish_test();
    end
  endtask
  // Bus and shifter tasks: all return 1 ns after the edge that took them
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic push(input logic [10:0] d);
    @(posedge sys_clk);
    rx_char <= d;
    rx_push <= 1'b1;
    @(posedge sys_clk);
    rx_push <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    chk({7'h00, tx_pin_n}, 8'h00);
    chk({7'h00, rx_pin_n}, 8'h01);
    rd(UFD_ADDR_LSTAT, 8'h60);
    rd(UFD_ADDR_FCTL, 8'h00);
  endtask
  // FIFOs off: one-character holding registers, second push overruns
  task automatic t_hold();
    push(11'h6A1);
    push(11'h0B2);
    rd(UFD_ADDR_LSTAT, 8'hFB);
    rd(UFD_ADDR_HOLD, 8'hA1);
    wr(UFD_ADDR_HOLD, 8'h5A);
    rd(UFD_ADDR_LSTAT, 8'h00);
  endtask
  task automatic t_poll();
    wr(UFD_ADDR_FCTL, 8'h07);
    wr(UFD_ADDR_IEN, 8'h00);
    push(11'h1C3);
    cyc(1);
    chk({7'h00, rx_pin_n}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rd(UFD_ADDR_LSTAT, 8'hE5);
    rd(UFD_ADDR_HOLD, 8'hC3);
    cyc(1);
    chk({7'h00, rx_pin_n}, 8'h01);
    rd(UFD_ADDR_LSTAT, 8'h60);
  endtask
  task automatic t_rx_trig();
    for (int c = 0; c < 4; c++) begin
      wr(UFD_ADDR_FCTL, {c[1:0], 6'h0F});
      wr(UFD_ADDR_IEN, 8'h01);
      for (int k = 1; k <= 32; k++) begin
        push(11'(k));
        chk({7'h00, irq}, {7'h00, k >= int'(rxl[c])});
        chk({7'h00, rx_pin_n}, {7'h00, k <= int'(rxl[c])});
      end
      push(11'h0FF);
      rd(UFD_ADDR_LSTAT, 8'h63);
      wr(UFD_ADDR_FCTL, {c[1:0], 6'h0B});
      cyc(1);
      chk({7'h00, rx_pin_n}, 8'h01);
      chk({7'h00, irq}, 8'h00);
    end
    push(11'h011);
    cyc(1);
    chk({7'h00, rx_pin_n}, 8'h01);
    @(posedge sys_clk);
    rx_timeout <= 1'b1;
    @(posedge sys_clk);
    rx_timeout <= 1'b0;
    cyc(2);
    chk({7'h00, rx_pin_n}, 8'h00);
  endtask
  // Block mode transmit: fill to full, drain and count takes to the trigger
  task automatic t_tx();
    for (int c = 0; c < 4; c++) begin
      wr(UFD_ADDR_FCTL, {2'b00, c[1:0], 4'hF});
      wr(UFD_ADDR_IEN, 8'h02);
      for (int k = 0; k < 32; k++) wr(UFD_ADDR_HOLD, 8'(k));
      cyc(1);
      chk({7'h00, tx_pin_n}, 8'h01);
      chk({7'h00, irq}, 8'h00);
      go <= 1'b1;
      n = 0;
      // Count the take while it stands, before the edge that samples it
      for (int i = 0; i < 2000 && irq !== 1'b1; i++) begin
        n += int'(tx_take);
        @(posedge sys_clk);
        #1;
      end
      wait_ok(irq);
      chk(8'(n), 8'(33 - int'(txl[c])));
      cyc(2);
      chk({7'h00, tx_pin_n}, 8'h00);
      for (int i = 0; i < 2000 && tx_avail !== 1'b0; i++) cyc(1);
      wait_ok(!tx_avail);
      rd(UFD_ADDR_LSTAT, 8'h20);
      cyc(12);
      rd(UFD_ADDR_LSTAT, 8'h60);
      go <= 1'b0;
    end
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_hold();
    t_poll();
    t_rx_trig();
    t_tx();
    finish_test();
  end
endmodule
